// file: hw/pll_params.svh
// Constants for the synthesizer mode and lock control block
`ifndef PLL_PARAMS_SVH
`define PLL_PARAMS_SVH
// Register indices; byte address is four times the index
`define IDX_CTRL 8'h1C
`define IDX_BAND 8'h1D
`define IDX_PROG 8'h1E
// Control register bit positions
`define CTRL_IRQ_EN 7
`define CTRL_FLAG 6
`define CTRL_PWR 5
`define CTRL_BSEL 4
`define CTRL_LOW_ONES 4'hF
// Bandwidth register bit positions
`define BAND_AUTO 7
`define BAND_LOCK 6
`define BAND_TRACK 5
// Program register fields and reset value
`define PROG_N_HI 7
`define PROG_N_LO 4
`define PROG_L_HI 3
`define PROG_L_LO 0
`define PROG_RESET 8'h00
`define BAND_RESET_AUTO 1'b0
// Nominal range unit in Hz, and divide of selected clock to bus rate
`define F_NOM_HZ 4915200
`define BUS_DIV_LAST 2'h3
// Frequency meter: window of reference edges, tolerances in counts
`define REF_WINDOW 8'h40
`define TOL_TRACK 8'h02
`define TOL_UNTRACK 8'h04
`define TOL_LOCK 8'h01
`define TOL_UNLOCK 8'h03
// AXI response codes
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// file: hw/pll_pkg.sv
// Types shared by the synthesizer control block
`default_nettype none
package pll_pkg;
    typedef struct packed {
        logic [9:0]  awaddr;
        logic        awvalid;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        wvalid;
        logic        bready;
        logic [9:0]  araddr;
        logic        arvalid;
        logic        rready;
    } axi_req_t;
    typedef struct packed {
        logic        awready;
        logic        wready;
        logic [1:0]  bresp;
        logic        bvalid;
        logic        arready;
        logic [31:0] rdata;
        logic [1:0]  rresp;
        logic        rvalid;
    } axi_rsp_t;
    typedef enum logic [1:0] {
        PD_IDLE = 2'b00,
        PD_UP   = 2'b01,
        PD_DOWN = 2'b10
    } pd_state_t;
endpackage
`default_nettype wire

// file: hw/pll_freq_meter.sv
// Counts feedback edges over a fixed window of reference edges
`include "pll_params.svh"
`default_nettype none
module pll_freq_meter (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       run,
    input  wire logic       ref_edge,
    input  wire logic       fb_edge,
    output logic [7:0]      fb_count,
    output logic            done
);
    logic [7:0] ref_cnt;
    logic [7:0] fb_cnt;
    wire        win_end = run & ref_edge & (ref_cnt == `REF_WINDOW - 8'h01);
    wire [7:0]  fb_inc  = (fb_cnt == 8'hFF) ? fb_cnt : fb_cnt + 8'h01;

    // ---------------------------------------------------------------
    // Window counters
    // ---------------------------------------------------------------
    // Saturating feedback count, so a runaway oscillator cannot wrap into range
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ref_cnt  <= 8'h00;
            fb_cnt   <= 8'h00;
            fb_count <= 8'h00;
            done     <= 1'b0;
        end else if (!run) begin
            ref_cnt <= 8'h00;
            fb_cnt  <= 8'h00;
            done    <= 1'b0;
        end else begin
            done <= win_end;
            if (win_end) begin
                fb_count <= fb_edge ? fb_inc : fb_cnt;
                ref_cnt  <= 8'h00;
                fb_cnt   <= 8'h00;
            end else begin
                if (ref_edge) ref_cnt <= ref_cnt + 8'h01;
                if (fb_edge) fb_cnt <= fb_inc;
            end
        end
    end
endmodule
`default_nettype wire

// file: hw/pll_mode_and_lock_control.sv
// Digital control of the frequency synthesizer: divider, phase, lock, registers
`include "pll_params.svh"
`default_nettype none
// Contract
// - Feedback clock is the oscillator clock divided by field N; the code toggles it once per N oscillator edges, a divide by 2N.
// - Phase compare issues up or down pulse sized by phase difference.
// - Mode and lock are judged from feedback versus reference frequency.
// - Filter-mode bit zero means acquisition, allowing large corrections.
// - Tracking mode whenever not acquiring or filter-mode bit is one.
// - Automatic setting one lets hardware switch acquisition and tracking.
// - Auto: filter-mode bit read-only, set within track, cleared beyond untrack.
// - Auto: settled bit read-only, set within lock, cleared beyond unlock.
// - Interrupt request when enable set and settled bit toggles.
// - Manual: filter-mode bit written by software selects the mode.
// - Manual: settled bit and all interrupt requests are suppressed.
// - Oscillator runs at four times bus rate; software picks N.
// - Program register holds N in upper nibble, L in lower.
// - Divider field zero behaves exactly as one.
// - Range field zero disables synth and blocks its selection.
// - Centre frequency is L times the nominal unit.
// - Change flag sets on settled toggle, clears on control read.
// - Source select forced zero while off or range field zero.
// - Program register ignores writes while power-on bit is one.
module pll_mode_and_lock_control (
    input  wire logic              clk,
    input  wire logic              rst_n,
    input  wire pll_pkg::axi_req_t axi_req,
    output pll_pkg::axi_rsp_t      axi_rsp,
    input  wire logic              osc_output_clock,
    input  wire logic              buffered_reference_clock,
    output logic                   feedback_divided_clock,
    output logic                   pump_up,
    output logic                   pump_down,
    output logic                   synth_enable,
    output logic                   filter_track_mode,
    output logic [3:0]             range_multiplier_field,
    output logic                   base_source_select,
    output logic                   bus_tick,
    output logic                   settle_irq_request
);
    // ---------------------------------------------------------------
    // State
    // ---------------------------------------------------------------
    logic             settle_irq_enable;
    logic             settle_change_flag;
    logic             synth_power_on;
    logic             auto_bw;
    logic             settled;
    logic             filter_track_select;
    logic [7:0]       synth_program_reg;
    logic             osc_prev;
    logic             ref_prev;
    logic [3:0]       div_cnt;
    logic             fb_edge;
    logic [1:0]       bus_cnt;
    logic             bvalid;
    logic [1:0]       bresp;
    logic             rvalid;
    logic [31:0]      rdata;
    logic [1:0]       rresp;
    logic [7:0]       fb_count;
    logic             meas_done;
    pll_pkg::pd_state_t pd_state;
    pll_pkg::pd_state_t next_pd_state;

    // ---------------------------------------------------------------
    // Field decode and edge detection
    // ---------------------------------------------------------------
    wire [3:0] n_field = synth_program_reg[`PROG_N_HI:`PROG_N_LO];
    wire [3:0] l_field = synth_program_reg[`PROG_L_HI:`PROG_L_LO];
    wire [3:0] n_eff   = (n_field == 4'h0) ? 4'h1 : n_field;
    wire synth_active  = synth_power_on & (l_field != 4'h0);
    wire osc_edge      = osc_output_clock & ~osc_prev;
    wire ref_edge      = buffered_reference_clock & ~ref_prev;
    wire div_wrap      = osc_edge & (div_cnt >= n_eff - 4'h1);

    // ---------------------------------------------------------------
    // Register bus decode
    // ---------------------------------------------------------------
    wire       wr_fire  = axi_req.awvalid & axi_req.wvalid & ~bvalid;
    wire [7:0] wr_idx   = axi_req.awaddr[9:2];
    wire       wr_map   = (wr_idx == `IDX_CTRL) | (wr_idx == `IDX_BAND)
                        | (wr_idx == `IDX_PROG);
    wire       wr_lane  = wr_fire & axi_req.wstrb[0];
    wire       wr_ctrl  = wr_lane & (wr_idx == `IDX_CTRL);
    wire       wr_band  = wr_lane & (wr_idx == `IDX_BAND);
    wire       wr_prog  = wr_lane & (wr_idx == `IDX_PROG) & ~synth_power_on;
    wire [7:0] wd       = axi_req.wdata[7:0];
    wire       rd_fire  = axi_req.arvalid & ~rvalid;
    wire [7:0] rd_idx   = axi_req.araddr[9:2];
    wire       rd_ctrl  = rd_fire & (rd_idx == `IDX_CTRL);

    // ---------------------------------------------------------------
    // Control register write effects
    // ---------------------------------------------------------------
    // Power cannot drop while the synth drives the base clock, and
    // power and source may not flip in one write, so a glitch-free
    // hand-over in the clock selector is always possible.
    wire next_power  = base_source_select ? 1'b1 : wd[`CTRL_PWR];
    wire bsel_legal  = synth_active & (wd[`CTRL_PWR] == synth_power_on);
    wire next_bsel_w = bsel_legal ? wd[`CTRL_BSEL] : base_source_select;

    // ---------------------------------------------------------------
    // Lock detector decisions
    // ---------------------------------------------------------------
    // feedback versus reference count
    wire [7:0] freq_err = (fb_count > `REF_WINDOW) ? fb_count - `REF_WINDOW
                                                   : `REF_WINDOW - fb_count;
    wire meas_ok   = meas_done & auto_bw;
    wire trk_set   = meas_ok & (freq_err <= `TOL_TRACK);
    wire trk_clr   = meas_ok & (freq_err > `TOL_UNTRACK);
    wire lock_set  = meas_ok & (freq_err <= `TOL_LOCK);
    wire lock_clr  = meas_ok & (freq_err > `TOL_UNLOCK);
    wire next_settled = (auto_bw & synth_active)
                      & (lock_set | (settled & ~lock_clr));
    wire settle_toggle = next_settled != settled;

    // ---------------------------------------------------------------
    // Frequency meter
    // ---------------------------------------------------------------
    // window count
    pll_freq_meter u_meter (
        .clk      (clk),
        .rst_n    (rst_n),
        .run      (synth_active & auto_bw),
        .ref_edge (ref_edge),
        .fb_edge  (fb_edge),
        .fb_count (fb_count),
        .done     (meas_done)
    );

    // ---------------------------------------------------------------
    // Input sampling, feedback divider and bus rate divider
    // ---------------------------------------------------------------
    // modulo divider on oscillator edges
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            osc_prev               <= 1'b0;
            ref_prev               <= 1'b0;
            div_cnt                <= 4'h0;
            fb_edge                <= 1'b0;
            feedback_divided_clock <= 1'b0;
        end else begin
            osc_prev <= osc_output_clock;
            ref_prev <= buffered_reference_clock;
            fb_edge  <= div_wrap & synth_active;
            if (!synth_active) div_cnt <= 4'h0;
            else if (div_wrap) div_cnt <= 4'h0;
            else if (osc_edge) div_cnt <= div_cnt + 4'h1;
            if (div_wrap & synth_active)
                feedback_divided_clock <= ~feedback_divided_clock;
        end
    end

    // bus rate is selected source over four
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            bus_cnt  <= 2'h0;
            bus_tick <= 1'b0;
        end else begin
            bus_tick <= 1'b0;
            if (base_source_select ? osc_edge : ref_edge) begin
                bus_cnt  <= bus_cnt + 2'h1;
                bus_tick <= (bus_cnt == `BUS_DIV_LAST);
            end
        end
    end

    // ---------------------------------------------------------------
    // Phase detector
    // ---------------------------------------------------------------
    // pulse lasts from leading edge to lagging edge
    always_comb begin
        next_pd_state = pd_state;
        unique case (pd_state)
            pll_pkg::PD_IDLE: begin
                if (ref_edge & ~fb_edge) next_pd_state = pll_pkg::PD_UP;
                else if (fb_edge & ~ref_edge) next_pd_state = pll_pkg::PD_DOWN;
            end
            pll_pkg::PD_UP: begin
                if (fb_edge) next_pd_state = pll_pkg::PD_IDLE;
            end
            pll_pkg::PD_DOWN: begin
                if (ref_edge) next_pd_state = pll_pkg::PD_IDLE;
            end
            default: next_pd_state = pll_pkg::PD_IDLE;
        endcase
        if (!synth_active) next_pd_state = pll_pkg::PD_IDLE;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) pd_state <= pll_pkg::PD_IDLE;
        else pd_state <= next_pd_state;
    end

    assign pump_up   = pd_state == pll_pkg::PD_UP;
    assign pump_down = pd_state == pll_pkg::PD_DOWN;

    // ---------------------------------------------------------------
    // Control register
    // ---------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            settle_irq_enable  <= 1'b0;
            synth_power_on     <= 1'b0;
            base_source_select <= 1'b0;
        end else begin
            if (wr_ctrl) begin
                // enable held low in manual mode
                settle_irq_enable  <= wd[`CTRL_IRQ_EN] & auto_bw;
                synth_power_on     <= next_power;
                base_source_select <= next_bsel_w & synth_active;
            end else if (!auto_bw) begin
                settle_irq_enable <= 1'b0;
            end
            if (!synth_active) base_source_select <= 1'b0;
        end
    end

    // set wins over the read clear
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) settle_change_flag <= 1'b0;
        else if (!auto_bw) settle_change_flag <= 1'b0;
        else if (settle_toggle) settle_change_flag <= 1'b1;
        else if (rd_ctrl) settle_change_flag <= 1'b0;
    end

    // ---------------------------------------------------------------
    // Bandwidth register and filter mode
    // ---------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            auto_bw             <= `BAND_RESET_AUTO;
            filter_track_select <= 1'b0;
            settled             <= 1'b0;
        end else begin
            if (wr_band) auto_bw <= wd[`BAND_AUTO];
            settled <= next_settled;
            if (auto_bw) begin
                if (!synth_active) filter_track_select <= 1'b0;
                else if (trk_set) filter_track_select <= 1'b1;
                else if (trk_clr) filter_track_select <= 1'b0;
            end else if (wr_band) begin
                filter_track_select <= wd[`BAND_TRACK];
            end
        end
    end

    // tracking whenever the bit is one
    assign filter_track_mode = filter_track_select;
    assign synth_enable      = synth_active;
    // centre frequency is L times the nominal unit
    assign range_multiplier_field = l_field;
    assign settle_irq_request = settle_change_flag & settle_irq_enable & auto_bw;

    // ---------------------------------------------------------------
    // Program register
    // ---------------------------------------------------------------
    // N high nibble, L low nibble
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) synth_program_reg <= `PROG_RESET;
        else if (wr_prog) synth_program_reg <= wd;
    end

    // ---------------------------------------------------------------
    // AXI4-Lite slave
    // ---------------------------------------------------------------
    // Address and data are taken together; unmapped offsets get SLVERR
    wire [7:0] ctrl_rd = {settle_irq_enable, settle_change_flag & auto_bw,
                          synth_power_on, base_source_select, `CTRL_LOW_ONES};
    wire [7:0] band_rd = {auto_bw, settled & auto_bw, filter_track_select, 5'h00};
    wire       rd_map  = (rd_idx == `IDX_CTRL) | (rd_idx == `IDX_BAND)
                       | (rd_idx == `IDX_PROG);
    wire [7:0] rd_mux  = (rd_idx == `IDX_CTRL) ? ctrl_rd
                       : (rd_idx == `IDX_BAND) ? band_rd
                       : (rd_idx == `IDX_PROG) ? synth_program_reg : 8'h00;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            bvalid <= 1'b0;
            bresp  <= `RESP_OKAY;
        end else if (wr_fire) begin
            bvalid <= 1'b1;
            bresp  <= wr_map ? `RESP_OKAY : `RESP_SLVERR;
        end else if (axi_req.bready) begin
            bvalid <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rvalid <= 1'b0;
            rdata  <= 32'h0000_0000;
            rresp  <= `RESP_OKAY;
        end else if (rd_fire) begin
            rvalid <= 1'b1;
            rdata  <= {24'h00_0000, rd_mux};
            rresp  <= rd_map ? `RESP_OKAY : `RESP_SLVERR;
        end else if (axi_req.rready) begin
            rvalid <= 1'b0;
        end
    end

    assign axi_rsp.awready = wr_fire;
    assign axi_rsp.wready  = wr_fire;
    assign axi_rsp.bvalid  = bvalid;
    assign axi_rsp.bresp   = bresp;
    assign axi_rsp.arready = rd_fire;
    assign axi_rsp.rvalid  = rvalid;
    assign axi_rsp.rdata   = rdata;
    assign axi_rsp.rresp   = rresp;

    // ---------------------------------------------------------------
    // Assertions
    // ---------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    a_fb_divide_wrap: assert property (
        synth_active && $stable(synth_program_reg) && div_wrap |=> fb_edge
        && feedback_divided_clock != $past(feedback_divided_clock))
        else $error("feedback divider missed its wrap");
    a_n_zero_one: assert property (
        synth_active && n_field == 4'h0 && osc_edge |=> fb_edge)
        else $error("zero divider field not treated as one");
    a_pd_up_start: assert property (
        synth_active && pd_state == pll_pkg::PD_IDLE && ref_edge && !fb_edge
        |=> pump_up && !pump_down)
        else $error("reference lead gave no up pulse");
    a_flag_on_toggle: assert property (
        auto_bw && settle_toggle |=> settle_change_flag)
        else $error("settled toggle did not set flag");
    a_flag_read_clr: assert property (
        auto_bw && rd_ctrl && !settle_toggle |=> !settle_change_flag)
        else $error("control read did not clear flag");
    a_irq_on_toggle: assert property (
        auto_bw && settle_irq_enable && settle_toggle && !wr_ctrl && !wr_band |=> settle_irq_request)
        else $error("enabled settled toggle raised no interrupt");
    a_manual_quiet: assert property (
        !auto_bw |=> !settle_irq_request && !settled)
        else $error("manual mode left lock or interrupt active");
    a_bsel_forced: assert property (
        !synth_active |=> !base_source_select)
        else $error("source select kept while synth unusable");
    a_prog_locked: assert property (
        synth_power_on |=> $stable(synth_program_reg))
        else $error("program register changed while powered");
    a_track_ro: assert property (
        auto_bw && !meas_ok && synth_active && $stable(synth_active)
        |=> $stable(filter_track_select))
        else $error("filter mode changed without a measurement");

    c_lock_gained: cover property (auto_bw && $rose(settled));
    c_irq_raised: cover property ($rose(settle_irq_request));
    c_synth_sel: cover property ($rose(base_source_select));
endmodule
`default_nettype wire

// file: verif/pll_mode_and_lock_control_tb.sv
// Self-checking bench for the synthesizer mode and lock control block
`include "pll_params.svh"
`default_nettype none
module pll_mode_and_lock_control_tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic              clk = 1'b0;
    logic              rst_n = 1'b0;
    logic              osc = 1'b0;
    logic              refc = 1'b0;
    logic              fast = 1'b0;
    logic [7:0]        cyc = 8'h00;
    pll_pkg::axi_req_t req = '0;
    pll_pkg::axi_rsp_t rsp;
    logic              fb, up, dn, sen, trk, bsel, tick, irq;
    logic [3:0]        lf;
    int                errors = 0;
    int                samples_checked = 0;
    int                t_fb, t_tk, t_up, t_dn, n;

    always #12.5 clk = ~clk;
    // Oscillator rises every 8 cycles (every 4 when fast), reference every 16
    always @(posedge clk) begin
        cyc  <= cyc + 8'h01;
        osc  <= fast ? cyc[1] : cyc[2];
        refc <= cyc[3];
    end

    pll_mode_and_lock_control u_pll_mode_and_lock_control (
        .clk(clk), .rst_n(rst_n), .axi_req(req), .axi_rsp(rsp),
        .osc_output_clock(osc), .buffered_reference_clock(refc),
        .feedback_divided_clock(fb), .pump_up(up), .pump_down(dn),
        .synth_enable(sen), .filter_track_mode(trk), .range_multiplier_field(lf),
        .base_source_select(bsel), .bus_tick(tick), .settle_irq_request(irq));

    // ------------------------------------------------------------
    // Checking and bus tasks
    // ------------------------------------------------------------
    task wrap_up;
        if (errors == 0 && samples_checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    task chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask

    task rng(input int got, input int lo, input int hi);
        samples_checked++;
        if (got < lo || got > hi) begin
            errors++;
            $display("unexpected at %0t: count %0d outside %0d..%0d", $time, got, lo, hi);
        end
    endtask

    task tmo;
        errors++;
        $display("unexpected at %0t: wait ran out", $time);
        wrap_up;
    endtask

    // Address and data are held until each channel's own ready is seen
    task wr(input logic [7:0] idx, input logic [7:0] d, input logic [1:0] er);
        int i;
        req.awaddr  <= {idx, 2'b00};
        req.awvalid <= 1'b1;
        req.wdata   <= {24'h00_0000, d};
        req.wstrb   <= 4'hF;
        req.wvalid  <= 1'b1;
        req.bready  <= 1'b1;
        for (i = 0; i < 50; i++) begin
            @(posedge clk);
            if (rsp.bvalid) break;
            if (rsp.awready) req.awvalid <= 1'b0;
            if (rsp.wready) req.wvalid <= 1'b0;
        end
        if (i == 50) tmo;
        chk(rsp.bresp, er);
    endtask

    task rd(input logic [7:0] idx, input logic [7:0] d, input logic [1:0] er);
        int i;
        req.araddr  <= {idx, 2'b00};
        req.arvalid <= 1'b1;
        req.rready  <= 1'b1;
        for (i = 0; i < 50; i++) begin
            @(posedge clk);
            if (rsp.rvalid) break;
            if (rsp.arready) req.arvalid <= 1'b0;
        end
        if (i == 50) tmo;
        chk(rsp.rdata, {24'h00_0000, d});
        chk(rsp.rresp, er);
    endtask

    // Counts edges and pulses; with stop set it ends on an interrupt request
    task run(input int cycles, input logic stop);
        int i;
        logic p;
        t_fb = 0; t_tk = 0; t_up = 0; t_dn = 0;
        p = fb;
        for (i = 0; i < cycles; i++) begin
            @(posedge clk);
            if (stop && irq === 1'b1) break;
            t_fb += int'(fb !== p);
            p = fb;
            t_tk += int'(tick === 1'b1);
            t_up += int'(up === 1'b1);
            t_dn += int'(dn === 1'b1);
        end
        if (stop && i == cycles) tmo;
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        rd(`IDX_CTRL, 8'h0F, `RESP_OKAY);
        rd(`IDX_BAND, 8'h00, `RESP_OKAY);
        rd(`IDX_PROG, `PROG_RESET, `RESP_OKAY);
        rd(8'hFF, 8'h00, `RESP_SLVERR);
        wr(8'hFF, 8'h00, `RESP_SLVERR);
        wr(`IDX_CTRL, 8'h10, `RESP_OKAY);
        rd(`IDX_CTRL, 8'h0F, `RESP_OKAY);
        wr(`IDX_BAND, 8'h20, `RESP_OKAY);
        rd(`IDX_BAND, 8'h20, `RESP_OKAY);
        chk(trk, 1'b1);
        wr(`IDX_BAND, 8'h00, `RESP_OKAY);
        chk(trk, 1'b0);
        wr(`IDX_CTRL, 8'h80, `RESP_OKAY);
        rd(`IDX_CTRL, 8'h0F, `RESP_OKAY);
        // Divider factors zero, one and two; zero must behave as one
        for (n = 0; n < 3; n++) begin
            wr(`IDX_BAND, 8'h00, `RESP_OKAY);
            wr(`IDX_PROG, {n[3:0], 4'h1}, `RESP_OKAY);
            wr(`IDX_CTRL, 8'h20, `RESP_OKAY);
            chk(sen, 1'b1);
            chk(lf, 4'h1);
            run(256, 1'b0);
            rng(t_fb, (n == 2) ? 15 : 31, (n == 2) ? 17 : 33);
            // Manual start-up: acquire, then track, then settle before selecting
            wr(`IDX_BAND, 8'h20, `RESP_OKAY);
            chk(trk, 1'b1);
            run(64, 1'b0);
            wr(`IDX_CTRL, 8'h30, `RESP_OKAY);
            chk(bsel, 1'b1);
            wr(`IDX_CTRL, 8'h20, `RESP_OKAY);
            chk(bsel, 1'b0);
            wr(`IDX_PROG, 8'h55, `RESP_OKAY);
            rd(`IDX_PROG, {n[3:0], 4'h1}, `RESP_OKAY);
            wr(`IDX_CTRL, 8'h00, `RESP_OKAY);
        end
        wr(`IDX_PROG, 8'h20, `RESP_OKAY);
        wr(`IDX_CTRL, 8'h20, `RESP_OKAY);
        chk(sen, 1'b0);
        wr(`IDX_CTRL, 8'h30, `RESP_OKAY);
        chk(bsel, 1'b0);
        wr(`IDX_CTRL, 8'h00, `RESP_OKAY);
        // Automatic mode with feedback matching the reference
        wr(`IDX_PROG, 8'h21, `RESP_OKAY);
        wr(`IDX_BAND, 8'h80, `RESP_OKAY);
        wr(`IDX_CTRL, 8'hA0, `RESP_OKAY);
        run(6000, 1'b1);
        rd(`IDX_BAND, 8'hE0, `RESP_OKAY);
        rd(`IDX_CTRL, 8'hEF, `RESP_OKAY);
        rd(`IDX_CTRL, 8'hAF, `RESP_OKAY);
        chk(irq, 1'b0);
        wr(`IDX_CTRL, 8'hB0, `RESP_OKAY);
        chk(bsel, 1'b1);
        run(1024, 1'b0);
        rng(t_tk, 31, 33);
        wr(`IDX_CTRL, 8'hA0, `RESP_OKAY);
        run(1024, 1'b0);
        rng(t_tk, 15, 17);
        // Oscillator pushed far off: lock and tracking must drop
        fast <= 1'b1;
        run(6000, 1'b1);
        rng(int'(t_dn > t_up), 1, 1);
        rd(`IDX_BAND, 8'h80, `RESP_OKAY);
        chk(trk, 1'b0);
        rd(`IDX_CTRL, 8'hEF, `RESP_OKAY);
        wr(`IDX_BAND, 8'h00, `RESP_OKAY);
        chk(irq, 1'b0);
        rd(`IDX_CTRL, 8'h2F, `RESP_OKAY);
        wrap_up;
    end
endmodule
`default_nettype wire
